// File: logic/dtc_pkg.sv
// shared constants and types for the termination and calibration link
package dtc_pkg;

  // command encodings on the link
  typedef enum logic [2:0] {
    DTC_CMD_NOP,
    DTC_CMD_ZQ_LONG,
    DTC_CMD_ZQ_SHORT,
    DTC_CMD_REFRESH,
    DTC_CMD_SR_ENTER,
    DTC_CMD_SR_EXIT,
    DTC_CMD_OTHER
  } dtc_cmd_t;

  // clock period in ps used to turn times into cycles
  localparam int DTC_CLK_PERIOD_PS = 50000;

  // timing figures in ps, plain defaults; cycle counts derived with round-up
  localparam int DTC_T_ZQINIT_PS = 25600000;
  localparam int DTC_T_ZQOPER_PS = 12800000;
  localparam int DTC_T_ZQCS_PS   = 3200000;
  localparam int DTC_T_RFC_PS    = 300000;
  localparam int DTC_T_CPDED_PS  = 100000;
  localparam int DTC_T_XPDLL_PS  = 600000;
  localparam int DTC_T_XS_PS     = 500000;
  localparam int DTC_T_RP_PS     = 150000;

  localparam int DTC_ZQINIT_CYC = (DTC_T_ZQINIT_PS + DTC_CLK_PERIOD_PS - 1) / DTC_CLK_PERIOD_PS;
  localparam int DTC_ZQOPER_CYC = (DTC_T_ZQOPER_PS + DTC_CLK_PERIOD_PS - 1) / DTC_CLK_PERIOD_PS;
  localparam int DTC_ZQCS_CYC   = (DTC_T_ZQCS_PS + DTC_CLK_PERIOD_PS - 1) / DTC_CLK_PERIOD_PS;
  localparam int DTC_RFC_CYC    = (DTC_T_RFC_PS + DTC_CLK_PERIOD_PS - 1) / DTC_CLK_PERIOD_PS;
  localparam int DTC_CPDED_CYC  = (DTC_T_CPDED_PS + DTC_CLK_PERIOD_PS - 1) / DTC_CLK_PERIOD_PS;
  localparam int DTC_XPDLL_CYC  = (DTC_T_XPDLL_PS + DTC_CLK_PERIOD_PS - 1) / DTC_CLK_PERIOD_PS;
  localparam int DTC_XS_CYC     = (DTC_T_XS_PS + DTC_CLK_PERIOD_PS - 1) / DTC_CLK_PERIOD_PS;
  localparam int DTC_RP_CYC     = (DTC_T_RP_PS + DTC_CLK_PERIOD_PS - 1) / DTC_CLK_PERIOD_PS;

  // write latency in cycles and the uncertainty span for odt changes in a window
  localparam int DTC_WL          = 5;
  localparam int DTC_ANPD_CYC    = DTC_WL - 1;
  localparam int DTC_ODT_SYNC_LAT = DTC_WL - 2;
  localparam int DTC_ODT_ASYNC_LAT = 1;
  localparam int DTC_ODT_MIN_LAT = 1;
  localparam int DTC_ODT_MAX_LAT = DTC_WL - 1;

  localparam int DTC_CNT_W = 16;

endpackage

// File: logic/dtc_link_if.sv
// command, cke, odt and dq pins between controller and memory end
`timescale 1ns/1ps
interface dtc_link_if;
  import dtc_pkg::*;
  dtc_cmd_t   cmd;
  logic       cke;
  logic       odt;
  logic       dq_out_ctl;
  logic       dq_oe_ctl;
  logic       dq_out_mem;
  logic       dq_oe_mem;

  modport ctl (output cmd, output cke, output odt, output dq_out_ctl, output dq_oe_ctl,
               input dq_out_mem, input dq_oe_mem);
  modport mem (input cmd, input cke, input odt, input dq_out_ctl, input dq_oe_ctl,
               output dq_out_mem, output dq_oe_mem);
endinterface

// File: logic/dtc_down_cnt.sv
// loadable down counter flagging when it runs out
`timescale 1ns/1ps
module dtc_down_cnt
  import dtc_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 load,
  input  wire logic [DTC_CNT_W-1:0] value,
  output      logic                 busy
);
  logic [DTC_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else if (load)
      cnt_q <= value;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  assign busy = (cnt_q != '0);
endmodule

// File: logic/dtc_mem_end.sv
// memory end: zq calibration engine and odt power-down transition windows
`timescale 1ns/1ps
module dtc_mem_end
  import dtc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  dtc_link_if.mem   link,
  input  wire logic dll_frozen_pd,
  output      logic zq_busy,
  output      logic zq_current_on,
  output      logic cal_updated,
  output      logic rtt_on,
  output      logic rtt_unknown,
  output      logic pd_active
);

  // =====================================================================
  // link sampling (pins arrive from the other party)
  logic [1:0] cke_s_q;
  logic [1:0] odt_s_q;
  dtc_cmd_t   cmd_s1_q;
  dtc_cmd_t   cmd_q;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cke_s_q  <= 2'h0;
      odt_s_q  <= 2'h0;
      cmd_s1_q <= DTC_CMD_NOP;
      cmd_q    <= DTC_CMD_NOP;
    end
    else
    begin
      cke_s_q  <= {cke_s_q[0], link.cke};
      odt_s_q  <= {odt_s_q[0], link.odt};
      cmd_s1_q <= link.cmd;
      cmd_q    <= cmd_s1_q;
    end
  end

  logic cke;
  logic odt;
  assign cke = cke_s_q[1];
  assign odt = odt_s_q[1];

  // memory never drives dq in this block
  assign link.dq_out_mem = 1'b0;
  assign link.dq_oe_mem  = 1'b0;

  // =====================================================================
  // zq calibration
  typedef enum logic [1:0] {DTC_ZQ_IDLE, DTC_ZQ_RUN, DTC_ZQ_XFER} dtc_zq_state_t;
  dtc_zq_state_t        zq_state_q;
  logic                 first_long_q;
  logic                 zq_load;
  logic [DTC_CNT_W-1:0] zq_len;
  logic                 zq_cnt_busy;

  always_comb
  begin
    zq_load = 1'b0;
    zq_len  = '0;
    if (zq_state_q == DTC_ZQ_IDLE)
    begin
      if (cmd_q == DTC_CMD_ZQ_LONG)
      begin
        zq_load = 1'b1;
        // the xfer cycle is part of the budget, hence minus one
        zq_len  = first_long_q ? DTC_CNT_W'(DTC_ZQINIT_CYC - 1)
                               : DTC_CNT_W'(DTC_ZQOPER_CYC - 1);
      end
      else if (cmd_q == DTC_CMD_ZQ_SHORT)
      begin
        zq_load = 1'b1;
        zq_len  = DTC_CNT_W'(DTC_ZQCS_CYC - 1);
      end
    end
  end

  dtc_down_cnt u_zq_cnt (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .load    (zq_load),
    .value   (zq_len),
    .busy    (zq_cnt_busy)
  );

  // self-refresh exit itself starts nothing; only explicit commands do
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      zq_state_q   <= DTC_ZQ_IDLE;
      first_long_q <= 1'b1;
    end
    else
    begin
      case (zq_state_q)
        DTC_ZQ_IDLE:
        begin
          if (zq_load)
            zq_state_q <= DTC_ZQ_RUN;
          if (cmd_q == DTC_CMD_ZQ_LONG)
            first_long_q <= 1'b0;
        end
        DTC_ZQ_RUN:
          if (!zq_cnt_busy)
            zq_state_q <= DTC_ZQ_XFER;
        DTC_ZQ_XFER:
          zq_state_q <= DTC_ZQ_IDLE;
        default:
          zq_state_q <= DTC_ZQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      zq_busy       <= 1'b0;
      zq_current_on <= 1'b0;
      cal_updated   <= 1'b0;
    end
    else
    begin
      zq_busy       <= zq_load || (zq_state_q == DTC_ZQ_RUN && zq_cnt_busy);
      zq_current_on <= zq_load || (zq_state_q == DTC_ZQ_RUN && zq_cnt_busy);
      cal_updated   <= (zq_state_q == DTC_ZQ_RUN) && !zq_cnt_busy;
    end
  end

  // =====================================================================
  // power-down transition windows
  // odt history lets the window reach back wl-1 cycles before the cke edge
  logic [DTC_ANPD_CYC-1:0] odt_hist_q;
  logic                    cke_d1_q;
  logic [DTC_CNT_W-1:0]    rfc_cnt_q;
  logic [DTC_CNT_W-1:0]    win_cnt_q;
  logic                    cke_fall;
  logic                    cke_rise;
  logic                    past_change;
  logic [DTC_CNT_W-1:0]    close_len;

  assign cke_fall = cke_d1_q && !cke;
  assign cke_rise = !cke_d1_q && cke;
  // toggles after the excluded starting cycle, up to now
  assign past_change = (odt_hist_q[DTC_ANPD_CYC-1:0] != {DTC_ANPD_CYC{odt_hist_q[0]}})
                       || (odt_hist_q[0] != odt);

  always_comb
  begin
    close_len = DTC_CNT_W'(DTC_CPDED_CYC);
    if (cke_rise)
      close_len = DTC_CNT_W'(DTC_XPDLL_CYC);
    else if (rfc_cnt_q > close_len)
      close_len = rfc_cnt_q;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      odt_hist_q <= '0;
      cke_d1_q   <= 1'b0;
      rfc_cnt_q  <= '0;
    end
    else
    begin
      odt_hist_q <= {odt_hist_q[DTC_ANPD_CYC-2:0], odt};
      cke_d1_q   <= cke;
      if (cmd_q == DTC_CMD_REFRESH)
        rfc_cnt_q <= DTC_CNT_W'(DTC_RFC_CYC);
      else if (rfc_cnt_q != '0)
        rfc_cnt_q <= rfc_cnt_q - 1'b1;
    end
  end

  // the close counter holds through the end cycle, so that cycle stays inside
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      win_cnt_q <= '0;
    else if (dll_frozen_pd && (cke_fall || cke_rise))
    begin
      // a later window extends an open one rather than cutting it short
      if (close_len > win_cnt_q)
        win_cnt_q <= close_len;
    end
    else if (win_cnt_q != '0)
      win_cnt_q <= win_cnt_q - 1'b1;
  end

  logic in_window;
  assign in_window = (win_cnt_q != '0) || (dll_frozen_pd && (cke_fall || cke_rise));

  // =====================================================================
  // termination response
  logic [DTC_ODT_SYNC_LAT-1:0] sync_pipe_q;
  logic [DTC_CNT_W-1:0]        unk_cnt_q;
  logic                        odt_change;
  logic                        async_mode;

  assign odt_change = odt != odt_hist_q[0];
  assign async_mode = dll_frozen_pd && !cke && (win_cnt_q == '0);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      sync_pipe_q <= '0;
    else
      sync_pipe_q <= {sync_pipe_q[DTC_ODT_SYNC_LAT-2:0], odt};
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      unk_cnt_q <= '0;
    else if ((cke_fall || cke_rise) && dll_frozen_pd && past_change)
      unk_cnt_q <= DTC_CNT_W'(DTC_ODT_MAX_LAT);
    else if (in_window && odt_change)
      unk_cnt_q <= DTC_CNT_W'(DTC_ODT_MAX_LAT);
    else if (unk_cnt_q != '0)
      unk_cnt_q <= unk_cnt_q - 1'b1;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rtt_on      <= 1'b0;
      rtt_unknown <= 1'b0;
      pd_active   <= 1'b0;
    end
    else
    begin
      pd_active   <= !cke;
      rtt_unknown <= (unk_cnt_q != '0) || (in_window && odt_change);
      if (zq_load || zq_busy)
        rtt_on <= 1'b0;
      else if (async_mode)
        rtt_on <= sync_pipe_q[DTC_ODT_ASYNC_LAT-1];
      else
        rtt_on <= sync_pipe_q[DTC_ODT_SYNC_LAT-1];
    end
  end

endmodule

// File: logic/dtc_ctl_end.sv
// controller end: issues calibration and keeps the channel quiet around it
`timescale 1ns/1ps
module dtc_ctl_end
  import dtc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  dtc_link_if.ctl   link,
  input  wire logic req_valid,
  input  wire dtc_cmd_t req_cmd,
  input  wire logic req_cke,
  input  wire logic req_odt,
  input  wire logic rank_zq_busy,
  output      logic req_ready,
  output      logic quiet
);

  // =====================================================================
  // guard timers
  logic [DTC_CNT_W-1:0] quiet_cnt_q;
  logic [DTC_CNT_W-1:0] xs_cnt_q;
  logic [DTC_CNT_W-1:0] rp_cnt_q;
  logic                 first_long_q;
  logic                 init_done_q;
  logic                 is_zq;
  logic                 take;
  dtc_cmd_t             eff_cmd;

  // power-up: force a long calibration before anything else
  assign eff_cmd = init_done_q ? req_cmd : DTC_CMD_ZQ_LONG;
  assign is_zq = (eff_cmd == DTC_CMD_ZQ_LONG) || (eff_cmd == DTC_CMD_ZQ_SHORT);
  // shared resistor: wait while a neighbour rank calibrates
  // ready shows one cycle after the take, so the cycle after a take is blocked
  // to keep a request that is still held from being issued twice
  assign take = (req_valid || !init_done_q) && quiet_cnt_q == '0 && !req_ready
                && !(is_zq && (rp_cnt_q != '0
                || xs_cnt_q != '0
                || rank_zq_busy));

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      quiet_cnt_q  <= '0;
      xs_cnt_q     <= '0;
      rp_cnt_q     <= DTC_CNT_W'(DTC_RP_CYC);
      first_long_q <= 1'b1;
      init_done_q  <= 1'b0;
    end
    else
    begin
      if (take && eff_cmd == DTC_CMD_ZQ_LONG)
      begin
        quiet_cnt_q  <= first_long_q ? DTC_CNT_W'(DTC_ZQINIT_CYC + 2)
                                     : DTC_CNT_W'(DTC_ZQOPER_CYC + 2);
        first_long_q <= 1'b0;
        init_done_q  <= 1'b1;
      end
      else if (take && eff_cmd == DTC_CMD_ZQ_SHORT)
        quiet_cnt_q <= DTC_CNT_W'(DTC_ZQCS_CYC + 2);
      else if (quiet_cnt_q != '0)
        quiet_cnt_q <= quiet_cnt_q - 1'b1;

      if (take && eff_cmd == DTC_CMD_SR_EXIT)
        xs_cnt_q <= DTC_CNT_W'(DTC_XS_CYC);
      else if (xs_cnt_q != '0)
        xs_cnt_q <= xs_cnt_q - 1'b1;

      // any access reopens banks in this model; precharge time restarts
      if (take && (eff_cmd == DTC_CMD_OTHER || eff_cmd == DTC_CMD_REFRESH))
        rp_cnt_q <= DTC_CNT_W'(DTC_RP_CYC);
      else if (rp_cnt_q != '0)
        rp_cnt_q <= rp_cnt_q - 1'b1;
    end
  end

  // =====================================================================
  // pin drive
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link.cmd        <= DTC_CMD_NOP;
      link.cke        <= 1'b0;
      link.odt        <= 1'b0;
      link.dq_out_ctl <= 1'b0;
      link.dq_oe_ctl  <= 1'b0;
      req_ready       <= 1'b0;
      quiet           <= 1'b0;
    end
    else
    begin
      link.cmd       <= take ? eff_cmd : DTC_CMD_NOP;
      req_ready      <= take && init_done_q;
      quiet          <= (quiet_cnt_q != '0) || (take && is_zq);
      link.dq_oe_ctl <= 1'b0;
      if ((quiet_cnt_q != '0) || (take && is_zq) || !init_done_q)
      begin
        link.cke <= 1'b1;
        link.odt <= 1'b0;
      end
      else
      begin
        link.cke <= req_cke;
        link.odt <= req_odt;
      end
    end
  end

endmodule

// File: verification/dtc_link_sva.sv
// assertions watching the termination and calibration link
`timescale 1ns/1ps
module dtc_link_sva
  import dtc_pkg::*;
(
  input wire logic     clk_sys,
  input wire logic     reset_n,
  input wire dtc_cmd_t cmd,
  input wire logic     cke,
  input wire logic     odt,
  input wire logic     dq_oe_ctl,
  input wire logic     dq_oe_mem,
  input wire logic     zq_busy,
  input wire logic     zq_current_on,
  input wire logic     cal_updated
);
  localparam int INIT_MAX = DTC_ZQINIT_CYC + 6;
  localparam int OPER_MAX = DTC_ZQOPER_CYC + 6;
  localparam int CS_MAX   = DTC_ZQCS_CYC + 6;
  logic        is_zq;
  logic        long_seen_q;
  logic [15:0] gap_q;
  // ==========
  // helpers
  assign is_zq = (cmd == DTC_CMD_ZQ_LONG) || (cmd == DTC_CMD_ZQ_SHORT);
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      long_seen_q <= 1'h0;
    else if (cmd == DTC_CMD_ZQ_LONG)
      long_seen_q <= 1'h1;
  end
  // counts the quiet window that each calibration command claims on the channel
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      gap_q <= 16'h0;
    else if (cmd == DTC_CMD_ZQ_LONG)
      gap_q <= long_seen_q ? 16'(DTC_ZQOPER_CYC) : 16'(DTC_ZQINIT_CYC);
    else if (cmd == DTC_CMD_ZQ_SHORT)
      gap_q <= 16'(DTC_ZQCS_CYC);
    else if (gap_q != 16'h0)
      gap_q <= gap_q - 16'h1;
  end
  // ==========
  // assertions
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_chan_quiet: assert property (gap_q != 16'h0 |-> cmd == DTC_CMD_NOP)
    else $error("command during calibration window");
  chk_cke_held: assert property (gap_q != 16'h0 |-> cke)
    else $error("cke low during calibration");
  chk_odt_off: assert property (gap_q != 16'h0 |-> !odt)
    else $error("odt high during calibration");
  chk_dq_released: assert property (!dq_oe_ctl && !dq_oe_mem)
    else $error("dq driven");
  chk_busy_start: assert property (is_zq |-> ##[2:4] zq_busy)
    else $error("calibration did not start");
  chk_busy_cause: assert property ($rose(zq_busy) |->
    $past(is_zq, 2) || $past(is_zq, 3) || $past(is_zq, 4))
    else $error("calibration without command");
  chk_init_time: assert property (cmd == DTC_CMD_ZQ_LONG && !long_seen_q |->
    ##[2:INIT_MAX] cal_updated)
    else $error("initial calibration too long");
  chk_oper_time: assert property (cmd == DTC_CMD_ZQ_LONG && long_seen_q |->
    ##[2:OPER_MAX] cal_updated)
    else $error("long calibration too long");
  chk_short_time: assert property (cmd == DTC_CMD_ZQ_SHORT |-> ##[2:CS_MAX] cal_updated)
    else $error("short calibration too long");
  chk_current_off: assert property ($fell(zq_busy) |=> !zq_current_on [*2])
    else $error("calibration current left on");
  chk_current_done: assert property (cal_updated |-> !zq_current_on)
    else $error("calibration current on at completion");
endmodule

// File: verification/tb_top.sv
// self-checking bench joining the controller end to the memory end
`timescale 1ns/1ps
module tb_top;
  import dtc_pkg::*;
  typedef struct { dtc_cmd_t c; int lim; } dtc_row_t;
  logic     clk_sys, reset_n, req_valid, req_cke, req_odt, rank_zq_busy, dll_frozen_pd;
  logic     req_ready, quiet, zq_busy, zq_current_on, cal_updated, rtt_on, rtt_unknown;
  logic     pd_active;
  dtc_cmd_t req_cmd;
  int       error_cnt;
  int       comparisons;
  int       n;
  dtc_row_t rows [4] = '{'{DTC_CMD_ZQ_SHORT, DTC_ZQCS_CYC + 6},
    '{DTC_CMD_ZQ_LONG, DTC_ZQOPER_CYC + 6}, '{DTC_CMD_REFRESH, 0}, '{DTC_CMD_OTHER, 0}};
  dtc_link_if link ();
  dtc_ctl_end dtc_ctl_end_i (.clk_sys(clk_sys), .reset_n(reset_n), .link(link.ctl),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_cke(req_cke), .req_odt(req_odt),
    .rank_zq_busy(rank_zq_busy), .req_ready(req_ready), .quiet(quiet));
  dtc_mem_end dtc_mem_end_i (.clk_sys(clk_sys), .reset_n(reset_n), .link(link.mem),
    .dll_frozen_pd(dll_frozen_pd), .zq_busy(zq_busy), .zq_current_on(zq_current_on),
    .cal_updated(cal_updated), .rtt_on(rtt_on), .rtt_unknown(rtt_unknown),
    .pd_active(pd_active));
  dtc_link_sva dtc_link_sva_i (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(link.cmd),
    .cke(link.cke), .odt(link.odt), .dq_oe_ctl(link.dq_oe_ctl), .dq_oe_mem(link.dq_oe_mem),
    .zq_busy(zq_busy), .zq_current_on(zq_current_on), .cal_updated(cal_updated));
  always #25 clk_sys = ~clk_sys;
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // request held until ready is sampled; the command stands in that same cycle
  task automatic send(input dtc_cmd_t c);
    @(posedge clk_sys);
    req_valid <= 1'h1;
    req_cmd   <= c;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (req_ready !== 1'h1 && n < 3000);
    req_valid <= 1'h0;
    chk(32'(link.cmd), 32'(c));
  endtask
  task automatic wait_cal(input int lim);
    n = 0;
    while (cal_updated !== 1'h1 && n <= lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n <= lim), 32'h1);
  endtask
  task automatic wait_unk();
    n = 0;
    while (rtt_unknown !== 1'h1 && n < 12)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n < 12), 32'h1);
  endtask
  // ==========
  // main sequence
  initial
  begin
    clk_sys = 1'h0;
    reset_n = 1'h0;
    req_valid = 1'h0;
    req_cmd = DTC_CMD_NOP;
    req_cke = 1'h1;
    req_odt = 1'h0;
    rank_zq_busy = 1'h0;
    dll_frozen_pd = 1'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_sys);
    chk(32'({link.cmd, link.cke, quiet, zq_busy}), 32'({DTC_CMD_NOP, 3'h0}));
    reset_n <= 1'h1;
    wait_cal(DTC_RP_CYC + DTC_ZQINIT_CYC + 8);
    $display("power-up calibration done");
    req_odt <= 1'h1;
    foreach (rows[i])
    begin
      send(rows[i].c);
      chk(32'({link.cke, link.odt}), 32'({1'h1, rows[i].lim == 0}));
      if (rows[i].lim > 0)
        wait_cal(rows[i].lim);
      $display("row %0d done", i);
    end
    req_odt <= 1'h0;
    rank_zq_busy <= 1'h1;
    fork
      send(DTC_CMD_ZQ_SHORT);
      begin
        repeat (20) @(posedge clk_sys);
        chk(32'(quiet), 32'h0);
        rank_zq_busy <= 1'h0;
      end
    join
    wait_cal(DTC_ZQCS_CYC + 6);
    $display("shared resistor test done");
    send(DTC_CMD_SR_ENTER);
    send(DTC_CMD_SR_EXIT);
    send(DTC_CMD_ZQ_SHORT);
    chk(32'(n + 1 >= DTC_XS_CYC), 32'h1);
    wait_cal(DTC_ZQCS_CYC + 6);
    $display("self refresh test done");
    dll_frozen_pd <= 1'h1;
    repeat (6) @(posedge clk_sys);
    req_cke <= 1'h0;
    req_odt <= 1'h1;
    wait_unk();
    repeat (30) @(posedge clk_sys);
    chk(32'({pd_active, rtt_unknown, rtt_on}), 32'h5);
    req_odt <= 1'h0;
    // a synchronous response would still show termination on here
    repeat (6) @(posedge clk_sys);
    chk(32'({rtt_unknown, rtt_on}), 32'h0);
    req_cke <= 1'h1;
    req_odt <= 1'h1;
    wait_unk();
    $display("power-down window test done");
    // refresh in flight at entry: odt moves after the short entry delay but
    // still inside the refresh time, so it must count as uncertain
    repeat (20) @(posedge clk_sys);
    send(DTC_CMD_REFRESH);
    req_cke <= 1'h0;
    repeat (4) @(posedge clk_sys);
    req_odt <= 1'h0;
    wait_unk();
    $display("refresh window test done");
    reset_n <= 1'h0;
    @(posedge clk_sys);
    chk(32'({link.cmd, link.cke, quiet, zq_busy, rtt_on}), 32'({DTC_CMD_NOP, 4'h0}));
    reset_n <= 1'h1;
    wait_cal(DTC_RP_CYC + DTC_ZQINIT_CYC + 8);
    $display("second reset test done");
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
endmodule
